// ---- rtl/ral_alarm.sv ----
// alarm match, interrupt pin and battery-backup gating of the clock/calendar
// assumes time fields and sec_tick come from the timekeeper on sys_clk,
// the backup level and pin readback come from outside and are synchronised
`timescale 1ns/100ps
`default_nettype none
module ral_alarm #(
	parameter int unsigned CNT_W = ral_pkg::PULSE_CNT_W,
	parameter logic [CNT_W-1:0] PULSE_LEN = CNT_W'(ral_pkg::PULSE_CYCLES)
) (
	input wire logic sys_clk, // system clock, 40 MHz
	input wire logic reset_n, // async reset, active low
	input wire logic clk_en, // freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire ral_pkg::ral_addr_t paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic sec_tick, // new time valid this cycle
	input wire ral_pkg::ral_byte_t now_sec, // current seconds, bcd
	input wire ral_pkg::ral_byte_t now_min, // current minutes, bcd
	input wire ral_pkg::ral_byte_t now_hour, // current hours, bcd
	input wire ral_pkg::ral_byte_t now_date, // current date, bcd
	input wire ral_pkg::ral_byte_t now_month, // current month, bcd
	input wire ral_pkg::ral_byte_t now_wday, // current weekday
	input wire logic on_backup_pin, // running from backup supply
	input wire logic alarm_freq_output_i, // open-drain pin level
	output logic alarm_freq_output_o, // pin drive value, always low
	output logic alarm_freq_output_oe, // high pulls the pin low
	output logic irq // level interrupt
);
	import ral_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [NUM_FIELDS-1:0][7:0] alarm;
		ral_byte_t int_ctrl;
		logic [STAT_W-1:0] status;
		logic [STAT_W-1:0] mask;
		logic [1:0] power;
		logic bk_s1;
		logic bk_s2;
		logic bk_d;
		logic pin_s1;
		logic pin_s2;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic pin_oe;
		logic irq;
	} ral_state_t;

	ral_state_t st;
	ral_state_t next_st;

	ral_cmp_if cmp_bus();
	logic std_backup;
	logic bus_blocked;
	logic pulse_mode;
	logic fire;
	logic pulse_start;
	logic pulse_busy;
	logic bus_write;
	logic setup;
	logic [STAT_W-1:0] set_bits;
	logic [STAT_W-1:0] clr_bits;

	////////////////////////////////////////////////////////////////////
	// helpers

	// aligned and inside the map
	function automatic logic addr_known(input ral_addr_t a);
		return (a[1:0] == 2'b00) && (a <= ADDR_STATE);
	endfunction

	function automatic logic [31:0] reg_read(input ral_addr_t a);
		logic [31:0] d;
		d = '0;
		if (a < ADDR_INT_CTRL) begin
			d[7:0] = st.alarm[a[4:2]];
		end else begin
			case (a)
				ADDR_INT_CTRL: d[7:0] = st.int_ctrl;
				ADDR_STATUS: d[STAT_W-1:0] = st.status;
				ADDR_IRQ_MASK: d[STAT_W-1:0] = st.mask;
				ADDR_POWER_CTRL: d[1:0] = st.power;
				ADDR_STATE: d[2:0] = {st.pin_s2, pulse_busy, st.bk_s2};
				default: d = '0;
			endcase
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////
	// comparator and pulse timer

	assign cmp_bus.alarm = st.alarm;
	assign cmp_bus.now = {now_wday, now_month, now_date, now_hour, now_min, now_sec};

	ral_match u_match (
		.cmp(cmp_bus)
	);

	ral_pulse #(
		.CNT_W(CNT_W),
		.LEN(PULSE_LEN)
	) u_pulse (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.start(pulse_start),
		.busy(pulse_busy)
	);

	////////////////////////////////////////////////////////////////////
	// power gating and alarm trigger

	// standard backup kills alarm, pin and bus but keeps the backup flag and irq; legacy keeps
	// alarm, and the bus too unless the inhibit bit is set
	assign std_backup = st.bk_s2 & !st.power[LEGACY_BIT];
	assign bus_blocked = st.bk_s2 & (!st.power[LEGACY_BIT] | st.power[INHIBIT_BIT]);
	assign pulse_mode = st.int_ctrl[PULSE_MODE_BIT];
	// compare only on the tick, so a match fires for one cycle per second
	assign fire = sec_tick & cmp_bus.hit & st.int_ctrl[ARM_BIT] & !std_backup;
	assign pulse_start = fire & pulse_mode;

	////////////////////////////////////////////////////////////////////
	// apb decode

	assign setup = psel & !penable;
	assign bus_write = psel & penable & st.pready & pwrite & !bus_blocked & addr_known(paddr);

	// set wins over a clear in the same cycle
	always_comb begin
		set_bits = '0;
		set_bits[FLAG_ALARM_BIT] = fire;
		set_bits[FLAG_BACKUP_BIT] = st.bk_s2 & !st.bk_d;
		clr_bits = '0;
		if (bus_write && paddr == ADDR_STATUS) begin
			clr_bits = pwdata[STAT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_st = st;
		// two-flop synchronisers, first stage read only by the second
		next_st.bk_s1 = on_backup_pin;
		next_st.bk_s2 = st.bk_s1;
		next_st.bk_d = st.bk_s2;
		next_st.pin_s1 = alarm_freq_output_i;
		next_st.pin_s2 = st.pin_s1;
		// zero-wait slave: ready rises for the access cycle only
		next_st.pready = setup;
		if (setup) begin
			next_st.pslverr = bus_blocked | !addr_known(paddr);
			next_st.prdata = (bus_blocked || !addr_known(paddr)) ? '0 : reg_read(paddr);
		end
		// writes land at the access edge
		if (bus_write) begin
			if (paddr < ADDR_INT_CTRL) begin
				next_st.alarm[paddr[4:2]] = pwdata[7:0];
			end else begin
				case (paddr)
					ADDR_INT_CTRL: next_st.int_ctrl = pwdata[7:0];
					ADDR_IRQ_MASK: next_st.mask = pwdata[STAT_W-1:0];
					ADDR_POWER_CTRL: next_st.power = pwdata[1:0];
					default: next_st.power = st.power;
				endcase
			end
		end
		next_st.status = (st.status & ~clr_bits) | set_bits;
		next_st.irq = |(next_st.status & next_st.mask);
		// single mode holds the pin until the flag clears; pulse mode
		// follows the timer and ignores the flag
		next_st.pin_oe = !std_backup & ((!pulse_mode & next_st.status[FLAG_ALARM_BIT])
			| pulse_start | pulse_busy);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.alarm <= {NUM_FIELDS{ALARM_RST}};
			st.int_ctrl <= INT_CTRL_RST;
			st.status <= STATUS_RST;
			st.mask <= MASK_RST;
			st.power <= POWER_RST;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign alarm_freq_output_o = 1'b0;
	assign alarm_freq_output_oe = st.pin_oe;
	assign irq = st.irq;

	////////////////////////////////////////////////////////////////////
	// checks
	// each |=> check looks at registered state one edge after its cause, so
	// clk_en must have been high on that cause edge; the timekeeper is
	// trusted to hold the time fields steady around sec_tick, while the
	// field-match checks compare hit against the fields at every edge

	a_minutes_enable_match: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		cmp_bus.hit && st.alarm[FLD_MIN][ALARM_EN_BIT]
		|-> (st.alarm[FLD_MIN] & BCD_MASK) == (now_min & BCD_MASK))
		else $error("minutes hit without equal minutes");

	a_hours_enable_match: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		cmp_bus.hit && st.alarm[FLD_HOUR][ALARM_EN_BIT]
		|-> (st.alarm[FLD_HOUR] & BCD_MASK) == (now_hour & BCD_MASK))
		else $error("hours hit without equal hours");

	a_date_month_match: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		cmp_bus.hit && st.alarm[FLD_DATE][ALARM_EN_BIT] && st.alarm[FLD_MONTH][ALARM_EN_BIT]
		|-> (st.alarm[FLD_DATE] & BCD_MASK) == (now_date & BCD_MASK)
		&& (st.alarm[FLD_MONTH] & BCD_MASK) == (now_month & BCD_MASK))
		else $error("date or month hit without equal value");

	a_blank_never_fires: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		st.alarm == '0 |-> !cmp_bus.hit)
		else $error("hit with every field blank");

	a_disarmed_no_fire: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		!st.int_ctrl[ARM_BIT] && clk_en |=> !$rose(st.status[FLAG_ALARM_BIT]))
		else $error("alarm flag rose while disarmed");

	a_single_pin_low: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		fire && clk_en && !pulse_mode
		|=> st.status[FLAG_ALARM_BIT] && st.pin_oe)
		else $error("single alarm did not set flag and pin");

	a_pulse_started: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		pulse_start && clk_en |=> pulse_busy && st.pin_oe)
		else $error("pulse mode match did not start a pulse");

	a_seconds_only_tick: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		fire && st.alarm[FLD_SEC][ALARM_EN_BIT]
		|-> sec_tick && (st.alarm[FLD_SEC] & BCD_MASK) == (now_sec & BCD_MASK))
		else $error("alarm fired off the second tick");

	a_pulse_ignores_flag: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		pulse_busy && !std_backup && clk_en ##1 !std_backup |-> st.pin_oe)
		else $error("pulse dropped while timer runs");

	a_std_backup_quiet: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		std_backup |-> !fire && !bus_write)
		else $error("activity in standard backup");

	a_std_backup_pin: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		std_backup && clk_en |=> !st.pin_oe)
		else $error("pin driven in standard backup");

	a_backup_entry_flag: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		st.bk_s2 && !st.bk_d && clk_en |=> st.status[FLAG_BACKUP_BIT])
		else $error("backup entry not flagged");

	a_inhibit_blocks_bus: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		setup && bus_blocked && clk_en |=> st.pready && st.pslverr && st.prdata == '0)
		else $error("blocked bus access not refused");

	a_flag_set_wins: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		fire && clk_en |=> st.status[FLAG_ALARM_BIT])
		else $error("alarm flag lost on a match");

	a_flag_pin_follow: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		clk_en && !pulse_mode && !pulse_busy && !pulse_start && !std_backup
		|=> st.pin_oe == st.status[FLAG_ALARM_BIT])
		else $error("single mode pin differs from flag");

	// cross-field, irq, backup and pulse checks: these catch a comparator, irq
	// or power gate that has drifted away from the field and mode rules
	a_sec_wday_match: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		cmp_bus.hit && st.alarm[FLD_SEC][ALARM_EN_BIT] && st.alarm[FLD_WDAY][ALARM_EN_BIT]
		|-> (st.alarm[FLD_SEC] & BCD_MASK) == (now_sec & BCD_MASK)
		&& (st.alarm[FLD_WDAY] & BCD_MASK) == (now_wday & BCD_MASK))
		else $error("seconds or weekday hit without equal value");

	a_irq_follows_status: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		clk_en |=> st.irq == |(st.status & st.mask))
		else $error("interrupt level differs from masked status");

	a_legacy_alarm_live: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		st.bk_s2 && st.power[LEGACY_BIT] && sec_tick && cmp_bus.hit && st.int_ctrl[ARM_BIT]
		&& clk_en |=> st.status[FLAG_ALARM_BIT])
		else $error("legacy backup lost an alarm");

	a_legacy_bus_open: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		setup && st.bk_s2 && st.power[LEGACY_BIT] && !st.power[INHIBIT_BIT]
		&& addr_known(paddr) && clk_en
		|=> st.pready && !st.pslverr)
		else $error("legacy backup bus access refused");

	a_pulse_ends_clean: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		pulse_mode && !pulse_busy && !pulse_start && clk_en |=> !st.pin_oe)
		else $error("pulse pin held past the timer");
endmodule
`default_nettype wire

// ---- rtl/ral_cmp_if.sv ----
// alarm/time compare bundle between the control block and the comparator
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface ral_cmp_if;
	logic [ral_pkg::NUM_FIELDS-1:0][7:0] alarm; // alarm field registers
	logic [ral_pkg::NUM_FIELDS-1:0][7:0] now; // current time fields, bcd
	logic hit; // all enabled fields equal, at least one field enabled

	modport src (output alarm, output now, input hit);
	modport cmp (input alarm, input now, output hit);
endinterface
`default_nettype wire

// ---- rtl/ral_match.sv ----
// comparator: every enabled alarm field against the running time
// assumes time fields are bcd and stable while they are compared
`timescale 1ns/100ps
`default_nettype none
module ral_match (
	ral_cmp_if.cmp cmp // alarm and time in, hit out
);
	import ral_pkg::*;

	// a field takes part only when nonzero and its enable bit is set
	function automatic logic field_ok(input ral_byte_t a, input ral_byte_t n);
		return (a == ALARM_RST) || !a[ALARM_EN_BIT] || ((a & BCD_MASK) == (n & BCD_MASK));
	endfunction

	// no enabled field means no alarm, so a blank setup never fires
	always_comb begin
		logic all_ok;
		logic any_en;
		all_ok = 1'b1;
		any_en = 1'b0;
		for (int i = 0; i < NUM_FIELDS; i++) begin
			all_ok = all_ok & field_ok(cmp.alarm[i], cmp.now[i]);
			any_en = any_en | cmp.alarm[i][ALARM_EN_BIT];
		end
		cmp.hit = all_ok & any_en;
	end
endmodule
`default_nettype wire

// ---- rtl/ral_pkg.sv ----
// constants for the alarm-match and interrupt block of the clock/calendar
// assumes a 40 MHz system clock and a 32-bit apb register port
package ral_pkg;

	typedef logic [7:0] ral_byte_t;
	typedef logic [7:0] ral_addr_t;

	// clock and time
	localparam int unsigned SYS_CLK_HZ = 40_000_000;
	localparam int unsigned PULSE_TIME_US = 250_000;
	localparam int unsigned PULSE_CYCLES = PULSE_TIME_US * (SYS_CLK_HZ / 1_000_000);
	localparam int unsigned PULSE_CNT_W = 24;

	// alarm fields: seconds, minutes, hours, date, month, weekday
	localparam int unsigned NUM_FIELDS = 6;
	localparam int unsigned FLD_SEC = 0;
	localparam int unsigned FLD_MIN = 1;
	localparam int unsigned FLD_HOUR = 2;
	localparam int unsigned FLD_DATE = 3;
	localparam int unsigned FLD_MONTH = 4;
	localparam int unsigned FLD_WDAY = 5;

	// register byte addresses
	localparam ral_addr_t ADDR_ALARM_SEC = 8'h00;
	localparam ral_addr_t ADDR_INT_CTRL = 8'h18;
	localparam ral_addr_t ADDR_STATUS = 8'h1c;
	localparam ral_addr_t ADDR_IRQ_MASK = 8'h20;
	localparam ral_addr_t ADDR_POWER_CTRL = 8'h24;
	localparam ral_addr_t ADDR_STATE = 8'h28;

	// field positions
	localparam int unsigned ALARM_EN_BIT = 7;
	localparam ral_byte_t BCD_MASK = 8'h7f;
	localparam int unsigned ARM_BIT = 5;
	localparam int unsigned PULSE_MODE_BIT = 7;
	localparam int unsigned STAT_W = 2;
	localparam int unsigned FLAG_ALARM_BIT = 0;
	localparam int unsigned FLAG_BACKUP_BIT = 1;
	localparam int unsigned LEGACY_BIT = 0;
	localparam int unsigned INHIBIT_BIT = 1;

	// values after reset
	localparam ral_byte_t ALARM_RST = 8'h00;
	localparam ral_byte_t INT_CTRL_RST = 8'h00;
	localparam logic [STAT_W-1:0] STATUS_RST = 2'h0;
	localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
	localparam logic [1:0] POWER_RST = 2'h0;

endpackage

// ---- rtl/ral_pulse.sv ----
// retriggerable pulse timer for the pulsed alarm output mode
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module ral_pulse #(
	parameter int unsigned CNT_W = ral_pkg::PULSE_CNT_W,
	parameter logic [CNT_W-1:0] LEN = CNT_W'(ral_pkg::PULSE_CYCLES)
) (
	input wire logic sys_clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic clk_en, // freezes the counter when low
	input wire logic start, // reload the pulse length
	output logic busy // pulse in progress
);
	import ral_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} ral_pulse_state_t;

	ral_pulse_state_t st;
	ral_pulse_state_t next_st;

	// a new trigger restarts the width rather than stretching past it
	always_comb begin
		next_st = st;
		if (start) begin
			next_st.cnt = LEN;
		end else if (st.cnt != '0) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign busy = (st.cnt != '0);
endmodule
`default_nettype wire

// ---- test/ral_alarm_tb.sv ----
// self-checking bench for the alarm-match and interrupt block
// assumes the host model drives apb; the bench plays timekeeper and pin
`timescale 1ns/100ps
`default_nettype none
module ral_alarm_tb;
	import ral_pkg::*;
	localparam int unsigned PL = 8;
	typedef struct packed {logic [47:0] al; logic [47:0] tm; logic hit;} ral_row_t;
	logic sys_clk, reset_n, clk_en, psel, penable, pwrite, pready, pslverr;
	logic sec_tick, on_backup_pin, pin, pin_o, pin_oe, irq;
	ral_addr_t paddr;
	logic [31:0] pwdata, prdata;
	ral_byte_t s, m, h, dt, mo, wd;
	int mismatches = 0;
	int total_checks = 0;
	ral_row_t rows [7];

	// open-drain pin with pull-up
	assign pin = pin_oe ? pin_o : 1'b1;

	ral_alarm #(.PULSE_LEN(24'(PL))) ral_alarm_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sec_tick(sec_tick), .now_sec(s), .now_min(m), .now_hour(h), .now_date(dt),
		.now_month(mo), .now_wday(wd), .on_backup_pin(on_backup_pin),
		.alarm_freq_output_i(pin), .alarm_freq_output_o(pin_o),
		.alarm_freq_output_oe(pin_oe), .irq(irq));
	ral_host_model ral_host_model_i (.sys_clk(sys_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input ral_addr_t a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		ral_host_model_i.xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input ral_addr_t a, input logic [31:0] exp, input logic ee);
		logic [31:0] r;
		logic e;
		ral_host_model_i.xfer(1'b0, a, 32'h0, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, ee});
	endtask
	// one-cycle new-second strobe; outputs settled on return
	task automatic tick(input logic [47:0] t);
		@(posedge sys_clk);
		sec_tick <= 1'b1;
		{wd, mo, dt, h, m, s} <= t;
		@(posedge sys_clk);
		sec_tick <= 1'b0;
		#1;
	endtask
	task automatic bk(input logic v);
		@(posedge sys_clk);
		on_backup_pin <= v;
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#250000;
		mismatches++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rows = '{'{48'h00_81_81_91_b0_00, 48'h03_01_01_11_30_00, 1'b1},
			'{48'h00_81_81_91_b0_00, 48'h03_01_01_11_31_00, 1'b0},
			'{48'h00_81_81_91_b0_00, 48'h03_02_01_11_30_00, 1'b0},
			'{48'h0, 48'h03_01_01_11_30_00, 1'b0},
			'{48'h00_00_00_00_00_b0, 48'h04_05_17_22_47_30, 1'b1},
			'{48'h85_00_00_00_00_00, 48'h05_12_31_23_59_58, 1'b1},
			'{48'h00_00_00_00_30_00, 48'h05_12_31_23_30_58, 1'b0}};
		reset_n = 1'b0;
		clk_en = 1'b1;
		sec_tick = 1'b0;
		on_backup_pin = 1'b0;
		{wd, mo, dt, h, m, s} = 48'h0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		#1;
		chk(irq, 0);
		chk(pin_oe, 0);
		rd(ADDR_INT_CTRL, 0, 0);
		rd(ADDR_STATUS, 0, 0);
		rd(ADDR_POWER_CTRL, 0, 0);
		rd(ADDR_STATE, 32'h4, 0);
		rd(8'h2c, 0, 1);
		wr(ADDR_IRQ_MASK, 1);
		$display("test reset done");
		// field encodings and combined match, one row at a time
		foreach (rows[i]) begin
			for (int f = 0; f < 6; f++) wr(ral_addr_t'(4 * f), {24'h0, rows[i].al[8*f+:8]});
			wr(ADDR_INT_CTRL, 32'h20);
			wr(ADDR_STATUS, 32'h3);
			tick(rows[i].tm);
			chk(pin_oe, rows[i].hit);
			chk(irq, rows[i].hit);
			rd(ADDR_STATUS, {31'h0, rows[i].hit}, 0);
			$display("test row %0d done", i);
		end
		// seconds-only alarm; disarmed it must stay quiet
		wr(ADDR_ALARM_SEC, 32'hb0);
		wr(ADDR_INT_CTRL, 32'h0);
		wr(ADDR_STATUS, 32'h3);
		tick(48'h30);
		chk(pin_oe, 0);
		rd(ADDR_STATUS, 0, 0);
		// single event latches through a non-matching second
		wr(ADDR_INT_CTRL, 32'h20);
		tick(48'h30);
		tick(48'h31);
		chk(pin_oe, 1);
		chk(irq, 1);
		wr(ADDR_STATUS, 32'h1);
		#1;
		chk(pin_oe, 0);
		chk(irq, 0);
		$display("test single done");
		// pulsed mode: fixed width, flag left set, retrigger anyway
		wr(ADDR_INT_CTRL, 32'ha0);
		tick(48'h30);
		chk(pin_oe, 1);
		repeat (PL) @(posedge sys_clk);
		#1;
		chk(pin_oe, 1);
		@(posedge sys_clk);
		#1;
		chk(pin_oe, 0);
		rd(ADDR_STATUS, 1, 0);
		tick(48'h30);
		chk(pin_oe, 1);
		repeat (PL + 2) @(posedge sys_clk);
		tick(48'h31);
		chk(pin_oe, 0);
		wr(ADDR_STATUS, 32'h3);
		$display("test pulse done");
		// standard backup: bus refused, no alarm
		wr(ADDR_INT_CTRL, 32'h20);
		bk(1'b1);
		rd(ADDR_STATUS, 0, 1);
		tick(48'h30);
		chk(pin_oe, 0);
		bk(1'b0);
		rd(ADDR_STATUS, 32'h2, 0);
		wr(ADDR_STATUS, 32'h3);
		$display("test standard done");
		// legacy backup: alarm live, bus live until inhibited
		wr(ADDR_POWER_CTRL, 32'h1);
		bk(1'b1);
		rd(ADDR_POWER_CTRL, 1, 0);
		tick(48'h30);
		chk(pin_oe, 1);
		wr(ADDR_POWER_CTRL, 32'h3);
		rd(ADDR_STATUS, 0, 1);
		bk(1'b0);
		rd(ADDR_STATUS, 32'h3, 0);
		$display("test legacy done");
		// mid-run reset must drop the latched flag, irq and power mode
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		#1;
		chk(irq, 0);
		chk(pin_oe, 0);
		rd(ADDR_STATUS, 0, 0);
		rd(ADDR_POWER_CTRL, 0, 0);
		$display("test mid reset done");
		test_done();
	end
endmodule
`default_nettype wire

// ---- test/ral_host_model.sv ----
// apb master standing in for the host microcontroller
// assumes one clock shared with the alarm block, zero or more wait states
`timescale 1ns/100ps
`default_nettype none
module ral_host_model (
	input wire logic sys_clk, // system clock
	output logic psel, // apb select
	output logic penable, // apb access phase
	output logic pwrite, // apb write
	output ral_pkg::ral_addr_t paddr, // apb byte address
	output logic [31:0] pwdata, // apb write data
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr // apb error
);
	import ral_pkg::*;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// one transfer; the bench programs every field before arming in the row tests, and
	// clears the flag between events so the next is seen, except in the pulse test, which retriggers with it set
	task automatic xfer(input logic w, input ral_addr_t a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// no cycle count assumed; a dead slave is left to the bench watchdog
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released address and data show the inverse, not a stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire
